/* File: sar_adc_config_accumulator.v */
`include "sar_adc_defs.vh"
module sar_adc_config_accumulator (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [7:0]  rdata,
    input  wire        hfosc_tick,
    input  wire        soc_in,
    output wire        sample_hold,
    output reg         convert_start,
    input  wire        convert_done,
    input  wire [11:0] convert_data,
    output wire [1:0]  resolution_mode,
    output wire        gain_select,
    output wire [1:0]  bias_power_select,
    output wire        mux_reference_low_power,
    output wire        buffer_low_power,
    output wire        irq
);
    localparam [5:0] ST_IDLE  = 6'b000001;
    localparam [5:0] ST_POWER = 6'b000010;
    localparam [5:0] ST_TRACK = 6'b000100;
    localparam [5:0] ST_START = 6'b001000;
    localparam [5:0] ST_CONV  = 6'b010000;
    localparam [5:0] ST_NEXT  = 6'b100000;

    reg  [7:0]  ctl_q;
    reg  [7:0]  cfg_q;
    reg  [7:0]  acc_cfg_q;
    reg  [7:0]  pwr_q;
    reg  [7:0]  mask_q;
    reg  [5:0]  state_q;
    reg  [7:0]  wait_q;
    reg  [6:0]  remain_q;
    reg  [1:0]  phase_q;
    reg  [17:0] sum_q;
    reg  [15:0] result_q;
    reg         soc_s1_q;
    reg         soc_s2_q;
    reg         soc_prev_q;
    reg         hf_s1_q;
    reg         hf_s2_q;
    reg         hf_prev_q;
    reg  [11:0] sample_w;
    reg  [15:0] fmt_w;
    wire        burst     = ctl_q[`CTL_BURST];
    wire        enable    = ctl_q[`CTL_ENABLE];
    wire        twelve    = acc_cfg_q[`ACC_TWELVE];
    wire        hf_pulse  = hf_s2_q & ~hf_prev_q;
    wire        soc_pulse = (soc_s2_q & ~soc_prev_q) |
                            (wr_en && addr == `ADDR_CONTROL && wdata[`CTL_START]);
    wire        clk_src   = burst ? hf_pulse : 1'b1;
    wire        sar_tick;
    wire        set_done;

    // Number of conversions for a repeat code; reserved codes act as code zero.
    function [6:0] repeat_count;
        input [2:0] code;
        input       tw;
        reg   [6:0] n;
        begin
            n = 7'h01;
            case (code)
                3'h1: n = 7'h04;
                3'h2: n = 7'h08;
                3'h3: n = 7'h10;
                3'h4: n = 7'h20;
                3'h5: n = 7'h40;
                default: n = 7'h01;
            endcase
            if (tw && n > 7'h01) begin
                n = n >> 2;
            end
            repeat_count = n;
        end
    endfunction

    sar_clock_divider u_div (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .clk_en            (clk_src),
        .sar_clock_divider (cfg_q[`CFG_DIV_HI:`CFG_DIV_LO]),
        .sar_tick          (sar_tick)
    );

    assign resolution_mode = twelve ? 2'h2 : (cfg_q[`CFG_EIGHT] ? 2'h0 : 2'h1);
    assign gain_select = cfg_q[`CFG_GAIN];
    assign bias_power_select = pwr_q[7:6];
    assign mux_reference_low_power = pwr_q[5];
    assign buffer_low_power = pwr_q[4];
    assign sample_hold = (state_q == ST_TRACK) || (state_q == ST_IDLE);
    assign irq = ctl_q[`CTL_DONE] & mask_q[`CTL_DONE];

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            soc_s1_q   <= 1'b0;
            soc_s2_q   <= 1'b0;
            soc_prev_q <= 1'b0;
            hf_s1_q    <= 1'b0;
            hf_s2_q    <= 1'b0;
            hf_prev_q  <= 1'b0;
        end else begin
            soc_s1_q   <= soc_in;
            soc_s2_q   <= soc_s1_q;
            soc_prev_q <= soc_s2_q;
            hf_s1_q    <= hfosc_tick;
            hf_s2_q    <= hf_s1_q;
            hf_prev_q  <= hf_s2_q;
        end
    end

    always @* begin
        sample_w = convert_data;
        if (cfg_q[`CFG_EIGHT] && !twelve) begin
            sample_w = {4'h0, convert_data[7:0]};
        end else if (!twelve) begin
            sample_w = {2'h0, convert_data[9:0]};
        end
    end

    always @* begin
        fmt_w = sum_q[15:0];
        case (acc_cfg_q[`ACC_SJ_HI:`ACC_SJ_LO])
            3'h1: fmt_w = sum_q[16:1];
            3'h2: fmt_w = sum_q[17:2];
            3'h3: fmt_w = {1'b0, sum_q[17:3]};
            3'h4: fmt_w = twelve ? {sum_q[11:0], 4'h0} :
                          (cfg_q[`CFG_EIGHT] ? {sum_q[7:0], 8'h00} : {sum_q[9:0], 6'h00});
            default: fmt_w = sum_q[15:0];
        endcase
    end

    assign set_done = (state_q == ST_NEXT) && (remain_q <= 7'h01);

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q       <= ST_IDLE;
            wait_q        <= 8'h00;
            remain_q      <= 7'h00;
            phase_q       <= 2'h0;
            sum_q         <= 18'h00000;
            convert_start <= 1'b0;
        end else begin
            convert_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (enable && soc_pulse) begin
                        remain_q <= burst ? repeat_count(acc_cfg_q[2:0], twelve) : 7'h01;
                        if (burst || !acc_cfg_q[`ACC_ACCUM]) begin
                            sum_q <= 18'h00000;
                        end
                        if (burst) begin
                            wait_q  <= pwr_q[`PWR_TIME_HI:`PWR_TIME_LO] * `PWR_CYC_PER_UNIT;
                            state_q <= ST_POWER;
                        end else if (cfg_q[`CFG_TRACK]) begin
                            wait_q  <= {4'h0, `TRACK_DELAY_SAR};
                            state_q <= ST_TRACK;
                        end else begin
                            state_q <= ST_START;
                        end
                    end
                end
                ST_POWER: begin
                    if (wait_q == 8'h00) begin
                        wait_q  <= cfg_q[`CFG_TRACK] ? {4'h0, `TRACK_DELAY_SAR} : 8'h00;
                        state_q <= cfg_q[`CFG_TRACK] ? ST_TRACK : ST_START;
                    end else if (hf_pulse) begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                ST_TRACK: begin
                    if (wait_q == 8'h00) begin
                        state_q <= ST_START;
                    end else if (sar_tick) begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                ST_START: begin
                    convert_start <= 1'b1;
                    phase_q       <= twelve ? 2'h3 : 2'h0;
                    wait_q        <= {3'h0, `CONV_SAR_CLOCKS};
                    state_q       <= ST_CONV;
                end
                ST_CONV: begin
                    if (sar_tick && wait_q != 8'h00) begin
                        wait_q <= wait_q - 8'h01;
                    end else if (wait_q == 8'h00 && convert_done) begin
                        if (phase_q != 2'h0) begin
                            phase_q <= phase_q - 2'h1;
                            wait_q  <= {3'h0, `CONV_SAR_CLOCKS};
                        end else begin
                            sum_q   <= sum_q + {6'h00, sample_w};
                            state_q <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    if (remain_q <= 7'h01) begin
                        remain_q <= 7'h00;
                        state_q  <= ST_IDLE;
                    end else begin
                        remain_q <= remain_q - 7'h01;
                        state_q  <= ST_START;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl_q     <= `RST_CONTROL;
            cfg_q     <= `RST_CONV_CFG;
            acc_cfg_q <= `RST_ACC_CFG;
            pwr_q     <= `RST_PWR_CTRL;
            mask_q    <= `RST_IRQ_MASK;
            result_q  <= 16'h0000;
            rdata     <= 8'h00;
        end else begin
            if (wr_en) begin
                if (addr == `ADDR_CONTROL) begin
                    ctl_q[7:6] <= wdata[7:6];
                end else if (addr == `ADDR_CONV_CFG) begin
                    cfg_q <= wdata;
                end else if (addr == `ADDR_ACC_CFG) begin
                    acc_cfg_q <= wdata;
                end else if (addr == `ADDR_PWR_CTRL) begin
                    pwr_q <= wdata;
                end else if (addr == `ADDR_IRQ_MASK) begin
                    mask_q <= wdata & 8'h20;
                end
            end
            if (set_done) begin
                ctl_q[`CTL_DONE] <= 1'b1;
            end else if (wr_en && addr == `ADDR_CONTROL && wdata[`CTL_DONE]) begin
                ctl_q[`CTL_DONE] <= 1'b0;
            end
            if (state_q == ST_NEXT) begin
                result_q <= fmt_w;
            end
            rdata <= 8'h00;
            if (rd_en) begin
                if (addr == `ADDR_CONTROL) begin
                    rdata <= {ctl_q[7:5], state_q != ST_IDLE, 4'h0};
                end else if (addr == `ADDR_CONV_CFG) begin
                    rdata <= cfg_q;
                end else if (addr == `ADDR_ACC_CFG) begin
                    rdata <= acc_cfg_q;
                end else if (addr == `ADDR_PWR_CTRL) begin
                    rdata <= pwr_q;
                end else if (addr == `ADDR_IRQ_MASK) begin
                    rdata <= mask_q;
                end else if (addr == `ADDR_RESULT_LOW) begin
                    rdata <= result_q[7:0];
                end else if (addr == `ADDR_RESULT_HIGH) begin
                    rdata <= result_q[15:8];
                end
            end
        end
    end
endmodule // sar_adc_config_accumulator

/* File: sar_adc_config_accumulator_bench.sv */
module sar_adc_config_accumulator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg         clk_sys, rst_n, wr_en, rd_en, soc_in;
    reg         hfosc_tick = 1'b0;
    reg  [7:0]  addr, wdata, r1;
    reg  [11:0] core_value;
    reg  [15:0] s1, s2;
    wire [7:0]  rdata;
    wire [11:0] convert_data;
    wire [1:0]  resolution_mode, bias_power_select;
    wire        sample_hold, convert_start, convert_done, gain_select;
    wire        mux_reference_low_power, buffer_low_power, irq;
    integer     bad_count, compares, base, i;
    integer     starts = 0;
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    bad_count = bad_count + 1; $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
    sar_adc_config_accumulator i_dut (.clk_sys, .rst_n, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .hfosc_tick, .soc_in, .sample_hold, .convert_start, .convert_done,
        .convert_data, .resolution_mode, .gain_select, .bias_power_select,
        .mux_reference_low_power, .buffer_low_power, .irq);
    sar_core_model i_core (.clk_sys, .rst_n, .convert_start, .core_value, .convert_done,
        .convert_data);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) hfosc_tick <= ~hfosc_tick;
    always @(posedge clk_sys) if (convert_start) starts <= starts + 1;
    task end_sim;
        begin
            $display("compares %0d bad_count %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr  <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge clk_sys);
            wr_en <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rd(input [7:0] a, output [7:0] v);
        begin
            addr  <= a;
            rd_en <= 1'b1;
            @(posedge clk_sys);
            rd_en <= 1'b0;
            @(negedge clk_sys);
            v = rdata;
            @(posedge clk_sys);
        end
    endtask
    task chk_rd(input [7:0] a, input [7:0] e);
        begin
            rd(a, r1);
            `CHK(r1, e)
        end
    endtask
    task rd_res;
        begin
            rd(8'hbe, s1[15:8]);
            rd(8'hbd, s1[7:0]);
        end
    endtask
    task wait_done;
        integer n;
        begin
            r1 = 8'h00;
            for (n = 0; n < 400 && !r1[5]; n = n + 1)
                rd(8'he8, r1);
            if (!r1[5]) begin
                bad_count = bad_count + 1;
                end_sim;
            end
        end
    endtask
    initial begin
        {wr_en, rd_en, soc_in, rst_n} = 4'h0;
        addr = 8'h00;
        wdata = 8'h00;
        core_value = 12'h0a5;
        bad_count = 0;
        compares = 0;
        base = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk_rd(8'hb3, 8'h00);
        chk_rd(8'hdf, 8'h0f);
        chk_rd(8'hbc, 8'hf8);
        chk_rd(8'he9, 8'h00);
        chk_rd(8'h55, 8'h00);
        wr(8'hbc, 8'h07);
        `CHK(resolution_mode, 2'h0)
        `CHK(gain_select, 1'b1)
        wr(8'hbc, 8'h00);
        `CHK(resolution_mode, 2'h1)
        `CHK(gain_select, 1'b0)
        wr(8'hb3, 8'h80);
        `CHK(resolution_mode, 2'h2)
        wr(8'hb3, 8'h00);
        wr(8'hdf, 8'hf1);
        `CHK({bias_power_select, mux_reference_low_power, buffer_low_power}, 4'hf)
        wr(8'he9, 8'h20);
        wr(8'he8, 8'h80);
        wr(8'he8, 8'h90);
        wait_done;
        `CHK(r1, 8'ha0)
        `CHK(irq, 1'b1)
        for (i = 0; i < 6; i = i + 1) begin
            wr(8'hb3, 8'(i * 8));
            wr(8'he8, 8'hb0);
            wait_done;
            rd_res;
            `CHK(s1, i == 4 ? 16'h2940 : 16'h00a5 >> (i > 4 ? 0 : i))
        end
        wr(8'hb3, 8'h00);
        wr(8'he8, 8'ha0);
        `CHK(irq, 1'b0)
        wr(8'he9, 8'h00);
        soc_in <= 1'b1;
        wait_done;
        soc_in <= 1'b0;
        `CHK(irq, 1'b0)
        wr(8'he8, 8'ha0);
        wr(8'hb3, 8'h40);
        wr(8'he8, 8'h90);
        wait_done;
        rd_res;
        s2 = s1;
        wr(8'he8, 8'hb0);
        wait_done;
        rd_res;
        `CHK(s1, s2 + 16'h00a5)
        wr(8'he8, 8'ha0);
        wr(8'hb3, 8'h00);
        wr(8'hbc, 8'h02);
        wr(8'he8, 8'h90);
        wait_done;
        wr(8'he8, 8'ha0);
        wr(8'hbc, 8'h00);
        wr(8'hdf, 8'h01);
        wr(8'he8, 8'hc0);
        wr(8'hb3, 8'h01);
        base = starts;
        wr(8'he8, 8'hd0);
        wait_done;
        `CHK(r1, 8'he0)
        `CHK(starts - base, 4)
        rd_res;
        `CHK(s1, 16'h0294)
        wr(8'he8, 8'he0);
        wr(8'hb3, 8'h81);
        base = starts;
        wr(8'he8, 8'hd0);
        wait_done;
        `CHK(starts - base, 1)
        rd_res;
        `CHK(s1, 16'h00a5)
        end_sim;
    end
endmodule // sar_adc_config_accumulator_bench

/* File: sar_adc_defs.vh */
// Behaviour
// - SAR clock is input clock over divider plus one.
// - Input clock: system clock, oscillator in burst.
// - Eight-bit select gives 8-bit conversions unless twelve-bit mode is set.
// - Normal tracking starts conversion at once.
// - Delayed tracking waits four SAR clocks before a single or first burst conversion.
// - Gain bit zero half, one unity.
// - Twelve-bit mode runs at quarter throughput.
// - Single mode stores latest or running sum.
// - Format field shifts right or left-justifies.
// - Burst repeat counts, quartered in twelve-bit.
// - Burst power-up waits eight oscillator cycles per unit.
// - Done flag after single or whole burst.
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH
`define ADDR_ACC_CFG      8'hb3
`define ADDR_PWR_CTRL     8'hdf
`define ADDR_CONV_CFG     8'hbc
`define ADDR_CONTROL      8'he8
`define ADDR_RESULT_LOW   8'hbd
`define ADDR_RESULT_HIGH  8'hbe
`define ADDR_IRQ_MASK     8'he9
`define RST_ACC_CFG       8'h00
`define RST_PWR_CTRL      8'h0f
`define RST_CONV_CFG      8'hf8
`define RST_CONTROL       8'h00
`define RST_IRQ_MASK      8'h00
`define CTL_ENABLE        7
`define CTL_BURST         6
`define CTL_DONE          5
`define CTL_START         4
`define CFG_DIV_HI        7
`define CFG_DIV_LO        3
`define CFG_EIGHT         2
`define CFG_TRACK         1
`define CFG_GAIN          0
`define ACC_TWELVE        7
`define ACC_ACCUM         6
`define ACC_SJ_HI         5
`define ACC_SJ_LO         3
`define ACC_RPT_HI        2
`define ACC_RPT_LO        0
`define PWR_TIME_HI       3
`define PWR_TIME_LO       0
`define TRACK_DELAY_SAR   4'h4
`define PWR_CYC_PER_UNIT  8'h08
`define CONV_SAR_CLOCKS   5'h10
`endif

/* File: sar_adc_monitor.sv */
module sar_adc_monitor (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr_en,
    input wire       rd_en,
    input wire [7:0] rdata,
    input wire       sample_hold,
    input wire       convert_start,
    input wire [1:0] resolution_mode,
    input wire       gain_select,
    input wire [1:0] bias_power_select,
    input wire       mux_reference_low_power,
    input wire       buffer_low_power,
    input wire       irq
);
    reg [7:0] cfg_q;
    reg [7:0] acc_q;
    reg       msk_q;
    reg       en_q;
    wire      wr_cfg = wr_en && addr == 8'hbc;
    wire      wr_acc = wr_en && addr == 8'hb3;
    wire      go = wr_en && addr == 8'he8 && wdata[7] && wdata[4] && !wdata[6] && en_q;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q <= 8'hf8;
            acc_q <= 8'h00;
            msk_q <= 1'b0;
            en_q  <= 1'b0;
        end else begin
            if (wr_cfg) cfg_q <= wdata;
            if (wr_acc) acc_q <= wdata;
            if (wr_en && addr == 8'he9) msk_q <= wdata[5];
            if (wr_en && addr == 8'he8) en_q <= wdata[7];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_start_one_cycle: assert property (
        convert_start |=> !convert_start [*8]) else $error("start pulse too close");
    a_normal_start: assert property (
        go && !cfg_q[1] && sample_hold |=> ##1 convert_start) else $error("no prompt start");
    a_delayed_track: assert property (
        go && cfg_q[1] && sample_hold |=> (!convert_start && sample_hold) [*5])
        else $error("delayed start too early");
    a_gain_follows: assert property (
        wr_cfg |=> gain_select == $past(wdata[0])) else $error("gain mismatch");
    a_eight_bit_mode: assert property (
        wr_cfg && wdata[2] && !acc_q[7] |=> resolution_mode == 2'h0) else $error("not 8-bit");
    a_twelve_bit_mode: assert property (
        wr_acc && wdata[7] && !cfg_q[2] |=> resolution_mode == 2'h2) else $error("not 12-bit");
    a_power_layout: assert property (
        wr_en && addr == 8'hdf |=>
        {bias_power_select, mux_reference_low_power, buffer_low_power} == $past(wdata[7:4]))
        else $error("power bits mismatch");
    a_irq_masked: assert property (
        irq |-> msk_q) else $error("irq while masked");
    a_acc_readback: assert property (
        rd_en && addr == 8'hb3 |=> rdata == acc_q) else $error("acc readback mismatch");
    cover property (convert_start);
    cover property (irq);
    cover property (wr_acc && wdata[7]);
endmodule // sar_adc_monitor

bind sar_adc_config_accumulator sar_adc_monitor i_mon (.clk_sys, .rst_n, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .sample_hold, .convert_start, .resolution_mode, .gain_select,
    .bias_power_select, .mux_reference_low_power, .buffer_low_power, .irq);

/* File: sar_clock_divider.v */
`include "sar_adc_defs.vh"
module sar_clock_divider (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire [4:0] sar_clock_divider,
    output reg        sar_tick
);
    reg [4:0] cnt_q;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q    <= 5'h00;
            sar_tick <= 1'b0;
        end else if (clk_en) begin
            if (cnt_q >= sar_clock_divider) begin
                cnt_q    <= 5'h00;
                sar_tick <= 1'b1;
            end else begin
                cnt_q    <= cnt_q + 5'h01;
                sar_tick <= 1'b0;
            end
        end else begin
            sar_tick <= 1'b0;
        end
    end
endmodule // sar_clock_divider

/* File: sar_core_model.sv */
module sar_core_model #(
    parameter LAT = 3
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        convert_start,
    input  wire [11:0] core_value,
    output reg         convert_done,
    output wire [11:0] convert_data
);
    timeunit 1ns;
    timeprecision 1ps;
    integer cnt;
    // Data is only valid while done is high; otherwise the inverse is shown.
    assign convert_data = convert_done ? core_value : ~core_value;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt          <= 0;
            convert_done <= 1'b0;
        end else if (convert_start) begin
            cnt          <= LAT;
            convert_done <= 1'b0;
        end else if (cnt != 0) begin
            cnt          <= cnt - 1;
            convert_done <= (cnt == 1);
        end
    end
endmodule // sar_core_model
